// file: logic/serial_status_flags.sv
// serial unit status flags with APB register access and interrupt
// Contract
// - overrun set when character ends with full
// - error flags reset; read one, write zero
// - receive disable leaves error flags alone
// - overrun keeps old data, halts receive
// - framing and parity only in asynchronous mode
// - framing set when stop bit is zero
// - two stop bits: check first only
// - framing error loads data, no full flag
// - parity set on odd/even mismatch
// - parity error loads data, no full flag
// - transmit end set if empty at last bit
// - transmit end set by reset, standby, disable
// - transmit end cleared by empty clear, dma write
// - transmit end read-only to software
// - multiprocessor bit captured, read-only
// - flags never written one; armed clear only
// - receive full set on good character
`timescale 1ns/100ps
`include "serial_defs.svh"
module serial_status_flags (
  input  wire logic        REF_CLK,     // 200 MHz clock
  input  wire logic        RST_B,       // async reset, active low
  input  wire logic        PSEL,        // apb select
  input  wire logic        PENABLE,     // apb enable
  input  wire logic        PWRITE,      // apb direction
  input  wire logic [11:0] PADDR,       // apb byte address
  input  wire logic [31:0] PWDATA,      // apb write data
  output logic      [31:0] PRDATA,      // apb read data
  output logic             PREADY,      // apb ready
  output logic             PSLVERR,     // unmapped address
  input  wire logic        STANDBY_PIN, // standby request, asynchronous
  input  wire logic        RX_END,      // pulse: final stop sample taken
  input  wire logic [7:0]  RX_CHAR,     // received character
  input  wire logic        RX_PAR_BIT,  // received parity bit
  input  wire logic        RX_STOP_BIT, // first stop bit sample
  input  wire logic        RX_MP_BIT,   // received multiprocessor bit
  input  wire logic        TX_LOAD,     // pulse: shifter took tx data
  input  wire logic        TX_LAST,     // pulse: last bit shifted out
  input  wire logic        DMA_TX_WR,   // pulse: dma writes tx data
  input  wire logic [7:0]  DMA_TX_DATA, // dma tx data
  input  wire logic        DMA_RX_RD,   // pulse: dma reads rx data
  output logic      [7:0]  RX_DATA,     // receive data register
  output logic      [7:0]  TX_DATA,     // transmit data register
  output logic             RX_HALT,     // reception halted
  output logic             TX_BLOCK,    // transmission blocked
  output logic             IRQ          // level interrupt
);
  import serial_pkg::*;

  logic [7:0]  ctrl_q;
  logic        txe_q, rxf_q, ovr_q, frm_q, par_q, tx_end_flag_q, mpb_q;
  logic [7:0]  arm_q;
  logic [4:0]  irq_st_q, irq_mask_q;
  logic        stby;
  logic        frm_err, par_err;
  rx_outcome_t outcome;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `OFS_STATUS) || (a == `OFS_CTRL) || (a == `OFS_RXDATA) ||
             (a == `OFS_TXDATA) || (a == `OFS_IRQ_ST) || (a == `OFS_IRQ_MASK);
  endfunction : mapped

  logic [7:0] status_vec;
  assign status_vec = {txe_q, rxf_q, ovr_q, frm_q, par_q, tx_end_flag_q, mpb_q, 1'b0};

  logic acc, wr_acc, rd_acc;
  assign acc    = PSEL && PENABLE && PREADY;
  assign wr_acc = acc && PWRITE && mapped(PADDR);
  assign rd_acc = acc && !PWRITE && mapped(PADDR);

  logic wr_status, wr_ctrl, wr_tx;
  assign wr_status = wr_acc && (PADDR == `OFS_STATUS);
  assign wr_ctrl   = wr_acc && (PADDR == `OFS_CTRL);
  assign wr_tx     = wr_acc && (PADDR == `OFS_TXDATA);

  // clear only where the bit was read as one and zero is written
  logic [7:0] sw_clr;
  assign sw_clr = wr_status ? (arm_q & ~PWDATA[7:0]) : 8'h00;

  logic tx_off;
  assign tx_off = wr_ctrl && ctrl_q[`C_TXON] && !PWDATA[`C_TXON];

  ////////////////////////////////////////////////////////////////////////////
  serial_sync2 u_stby (
    .clk   (REF_CLK),
    .rst_b (RST_B),
    .d     (STANDBY_PIN),
    .q     (stby)
  );

  serial_rx_check u_chk (
    .rx_end    (RX_END),
    .rx_on     (ctrl_q[`C_RXON]),
    .halted    (ovr_q || frm_q || par_q),
    .rx_full   (rxf_q),
    .sync_mode (ctrl_q[`C_SYNC]),
    .par_en    (ctrl_q[`C_PEN]),
    .par_odd   (ctrl_q[`C_ODD]),
    .rx_char   (RX_CHAR),
    .par_bit   (RX_PAR_BIT),
    .stop_bit  (RX_STOP_BIT),
    .outcome   (outcome),
    .frm_err   (frm_err),
    .par_err   (par_err)
  );

  logic rx_good, rx_over, rx_bad;
  always_comb begin
    rx_good = 1'b0;
    rx_over = 1'b0;
    rx_bad  = 1'b0;
    unique case (outcome)
      RXO_NONE: ;
      RXO_GOOD: rx_good = 1'b1;
      RXO_OVER: rx_over = 1'b1;
      RXO_BAD:  rx_bad  = 1'b1;
      default:  ;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb: ready rises in the first access cycle, so every transfer is two cycles
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !mapped(PADDR);
      if (PSEL && !PENABLE) begin
        case (PADDR)
          `OFS_STATUS:   PRDATA <= {24'h00_0000, status_vec};
          `OFS_CTRL:     PRDATA <= {24'h00_0000, ctrl_q};
          `OFS_RXDATA:   PRDATA <= {24'h00_0000, RX_DATA};
          `OFS_TXDATA:   PRDATA <= {24'h00_0000, TX_DATA};
          `OFS_IRQ_ST:   PRDATA <= {27'h000_0000, irq_st_q};
          `OFS_IRQ_MASK: PRDATA <= {27'h000_0000, irq_mask_q};
          default:       PRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_q <= `CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= PWDATA[7:0];
    end
  end

  // arming uses the value sent out, so a flag set after the read stays put
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      arm_q <= 8'h00;
    end else if (stby || wr_status) begin
      arm_q <= 8'h00;
    end else if (rd_acc && PADDR == `OFS_STATUS) begin
      arm_q <= arm_q | PRDATA[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // error flags: rx enable is not looked at here, so disabling keeps them
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ovr_q <= 1'b0;
    end else if (stby) begin
      ovr_q <= 1'b0;
    end else if (rx_over) begin
      ovr_q <= 1'b1;
    end else if (sw_clr[`B_OVR]) begin
      ovr_q <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      frm_q <= 1'b0;
    end else if (stby) begin
      frm_q <= 1'b0;
    end else if (rx_bad && frm_err) begin
      frm_q <= 1'b1;
    end else if (sw_clr[`B_FRM]) begin
      frm_q <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      par_q <= 1'b0;
    end else if (stby) begin
      par_q <= 1'b0;
    end else if (rx_bad && par_err) begin
      par_q <= 1'b1;
    end else if (sw_clr[`B_PAR]) begin
      par_q <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rxf_q <= 1'b0;
    end else if (stby) begin
      rxf_q <= 1'b0;
    end else if (rx_good) begin
      rxf_q <= 1'b1;
    end else if (sw_clr[`B_RXF] || DMA_RX_RD) begin
      rxf_q <= 1'b0;
    end
  end

  // overrun leaves the old character; errored characters are still loaded
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      RX_DATA <= 8'h00;
    end else if (rx_good || rx_bad) begin
      RX_DATA <= RX_CHAR;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      mpb_q <= 1'b0;
    end else if (stby) begin
      mpb_q <= 1'b0;
    end else if ((rx_good || rx_bad) && ctrl_q[`C_MPF] && !ctrl_q[`C_SYNC]) begin
      mpb_q <= RX_MP_BIT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      txe_q <= 1'b1;
    end else if (stby || tx_off || TX_LOAD) begin
      txe_q <= 1'b1;
    end else if (sw_clr[`B_TXE] || DMA_TX_WR) begin
      txe_q <= 1'b0;
    end
  end

  // software has no direct write path; only its txe clear and transmit disable reach this flag
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      tx_end_flag_q <= 1'b1;
    end else if (stby || tx_off) begin
      tx_end_flag_q <= 1'b1;
    end else if (TX_LAST && txe_q) begin
      tx_end_flag_q <= 1'b1;
    end else if (sw_clr[`B_TXE] || DMA_TX_WR) begin
      tx_end_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      TX_DATA <= 8'h00;
    end else if (DMA_TX_WR) begin
      TX_DATA <= DMA_TX_DATA;
    end else if (wr_tx) begin
      TX_DATA <= PWDATA[7:0];
    end
  end

  // one cycle behind the flags; the receive gate itself uses the flags direct
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      RX_HALT  <= 1'b0;
      TX_BLOCK <= 1'b0;
    end else begin
      RX_HALT  <= ovr_q || frm_q || par_q;
      TX_BLOCK <= ctrl_q[`C_SYNC] && (ovr_q || frm_q || par_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [4:0] irq_ev;
  assign irq_ev = {rx_good, TX_LAST && txe_q && !tx_end_flag_q, rx_bad && par_err,
                   rx_bad && frm_err, rx_over};

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      irq_st_q <= `IRQ_RST;
    end else begin
      irq_st_q <= (irq_st_q & ~((wr_acc && PADDR == `OFS_IRQ_ST) ? PWDATA[4:0] : 5'h00)) | irq_ev;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      irq_mask_q <= `IRQ_RST;
    end else if (wr_acc && PADDR == `OFS_IRQ_MASK) begin
      irq_mask_q <= PWDATA[4:0];
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_st_q & irq_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);

  AST_OVR_SET: assert property (rx_over |=> ovr_q)
    else $error("overrun flag not set");
  AST_OVR_KEEP_DATA: assert property (rx_over |=> $stable(RX_DATA) && !rxf_q == 1'b0)
    else $error("overrun changed receive data");
  AST_NO_SW_SET: assert property (!stby && !ovr_q && !rx_over |=> !ovr_q)
    else $error("overrun flag set without cause");
  AST_RXOFF_HOLD: assert property (wr_ctrl && !PWDATA[0] && !stby && !wr_status |=> $stable(frm_q))
    else $error("framing flag changed on receive disable");
  AST_FRM_SET: assert property (RX_END && ctrl_q[0] && !ctrl_q[2] && !RX_STOP_BIT && !rxf_q
                                && !(ovr_q || frm_q || par_q) |=> frm_q && !rxf_q && RX_DATA == $past(RX_CHAR))
    else $error("framing error handling wrong");
  AST_SYNC_NO_FRM: assert property (ctrl_q[2] && !frm_q && !stby |=> !frm_q)
    else $error("framing flag set in synchronous mode");
  AST_PAR_NO_FULL: assert property (rx_bad && par_err |=> par_q && !rxf_q)
    else $error("parity error handling wrong");
  AST_TX_END_FLAG_SET: assert property (TX_LAST && txe_q |=> tx_end_flag_q)
    else $error("transmit end not set");
  AST_TX_END_FLAG_CLR: assert property (DMA_TX_WR && !stby && !tx_off && !TX_LAST |=> !tx_end_flag_q && !txe_q)
    else $error("dma write did not clear transmit end");
  AST_TX_END_FLAG_RO: assert property (wr_status && !sw_clr[7] && !DMA_TX_WR |=> tx_end_flag_q >= $past(tx_end_flag_q))
    else $error("software write touched transmit end");
  AST_GOOD_FULL: assert property (rx_good |=> rxf_q ##1 (rxf_q || $past(DMA_RX_RD) || $past(sw_clr[6])))
    else $error("receive full not set");
  AST_BLOCK: assert property (ctrl_q[2] && ovr_q ##1 ctrl_q[2] && ovr_q |-> TX_BLOCK && RX_HALT)
    else $error("sync transmit not blocked");

  COV_OVERRUN: cover property (rx_over ##1 ovr_q);
  COV_FRAMING: cover property (rx_bad && frm_err);
  COV_TX_END_FLAG:    cover property (TX_LAST && txe_q ##1 IRQ);
  COV_CLEAR:   cover property (sw_clr[`B_OVR]);
endmodule : serial_status_flags

// file: logic/serial_defs.svh
// register offsets, field positions and reset values of the serial status block
`ifndef SERIAL_DEFS_SVH
`define SERIAL_DEFS_SVH
`define OFS_STATUS   12'h000
`define OFS_CTRL     12'h004
`define OFS_RXDATA   12'h008
`define OFS_TXDATA   12'h00C
`define OFS_IRQ_ST   12'h010
`define OFS_IRQ_MASK 12'h014
`define B_TXE        7
`define B_RXF        6
`define B_OVR        5
`define B_FRM        4
`define B_PAR        3
`define B_TX_END_FLAG       2
`define B_MPB        1
`define C_RXON       0
`define C_TXON       1
`define C_SYNC       2
`define C_PEN        3
`define C_ODD        4
`define C_STOP2      5
`define C_MPF        6
`define I_OVR        0
`define I_FRM        1
`define I_PAR        2
`define I_TX_END_FLAG       3
`define I_RXF        4
`define STATUS_RST   8'h84
`define CTRL_RST     8'h00
`define IRQ_RST      5'h00
`endif

// file: logic/serial_pkg.sv
// types shared by the serial status block
package serial_pkg;
  typedef enum logic [3:0] {
    RXO_NONE = 4'h1,
    RXO_GOOD = 4'h2,
    RXO_OVER = 4'h4,
    RXO_BAD  = 4'h8
  } rx_outcome_t;
endpackage : serial_pkg

// file: logic/serial_sync2.sv
// two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/100ps
module serial_sync2 (
  input  wire logic clk,   // sampling clock
  input  wire logic rst_b, // async reset, active low
  input  wire logic d,     // asynchronous level
  output logic      q      // synchronised level
);
  logic meta_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : serial_sync2

// file: logic/serial_rx_check.sv
// classifies a finished received character: good, overrun, or framing/parity error
`timescale 1ns/100ps
module serial_rx_check
  import serial_pkg::*;
(
  input  wire logic        rx_end,    // final stop sample taken
  input  wire logic        rx_on,     // receiver enabled
  input  wire logic        halted,    // an error flag is set
  input  wire logic        rx_full,   // receive-full flag
  input  wire logic        sync_mode, // synchronous mode
  input  wire logic        par_en,    // parity enabled
  input  wire logic        par_odd,   // odd parity selected
  input  wire logic [7:0]  rx_char,   // received character
  input  wire logic        par_bit,   // received parity bit
  input  wire logic        stop_bit,  // first stop bit sample
  output serial_pkg::rx_outcome_t outcome, // classification
  output logic             frm_err,   // framing error seen
  output logic             par_err    // parity error seen
);
  function automatic logic ones_odd(input logic [7:0] c, input logic p);
    ones_odd = ^{c, p};
  endfunction : ones_odd

  always_comb begin
    // only the first stop bit is looked at, so a second one never matters
    frm_err = !sync_mode && !stop_bit;
    par_err = !sync_mode && par_en && (ones_odd(rx_char, par_bit) != par_odd);
    if (!rx_end || !rx_on || halted)
      outcome = RXO_NONE;
    else if (rx_full)
      outcome = RXO_OVER;
    else if (frm_err || par_err)
      outcome = RXO_BAD;
    else
      outcome = RXO_GOOD;
  end
endmodule : serial_rx_check

// file: dv/serial_peer.sv
// behavioural serial peer: delivers received characters and transmit shifter pulses
`timescale 1ns/100ps
module serial_peer (
  input  wire logic       clk,      // bench clock
  output logic            rx_end,   // final stop sample pulse
  output logic      [7:0] rx_char,  // received character
  output logic            par_bit,  // received parity bit
  output logic            stop_bit, // first stop bit sample
  output logic            mp_bit,   // multiprocessor bit
  output logic            tx_load,  // shifter took data
  output logic            tx_last   // last bit shifted out
);
  initial begin
    rx_end = 1'b0;
    rx_char = 8'h00;
    par_bit = 1'b0;
    stop_bit = 1'b1;
    mp_bit = 1'b0;
    tx_load = 1'b0;
    tx_last = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // gap gives slow or prompt delivery; between frames the lines show the inverse, not stale data
  task automatic send(input logic [7:0] ch, input logic p, input logic s, input logic m, input int gap);
    repeat (gap + 1) @(posedge clk);
    rx_end <= 1'b1;
    rx_char <= ch;
    par_bit <= p;
    stop_bit <= s;
    mp_bit <= m;
    @(posedge clk);
    rx_end <= 1'b0;
    rx_char <= ~ch;
    par_bit <= ~p;
    stop_bit <= ~s;
    mp_bit <= ~m;
  endtask : send
  task automatic tx_pulse(input logic load);
    @(posedge clk);
    if (load) tx_load <= 1'b1;
    else tx_last <= 1'b1;
    @(posedge clk);
    tx_load <= 1'b0;
    tx_last <= 1'b0;
  endtask : tx_pulse
endmodule : serial_peer

// file: dv/tb.sv
// self-checking bench for the serial status flag block
`timescale 1ns/100ps
`include "serial_defs.svh"
module tb;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, rx_end, rx_par, rx_stop, rx_mp, tx_load, tx_last;
  logic        standby = 1'b0;
  logic        dma_wr = 1'b0;
  logic        dma_rd = 1'b0;
  logic [7:0]  dma_data = 8'h00;
  logic [7:0]  rx_char, rx_data, tx_data;
  logic        rx_halt, tx_block, irq;
  logic [31:0] r;
  logic        e;
  int          st, ctl, arm, rxd, txd, miscompares, comparisons;
  always #2.5 ref_clk = ~ref_clk;
  serial_status_flags dut_u (.REF_CLK(ref_clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .STANDBY_PIN(standby), .RX_END(rx_end), .RX_CHAR(rx_char), .RX_PAR_BIT(rx_par), .RX_STOP_BIT(rx_stop),
    .RX_MP_BIT(rx_mp), .TX_LOAD(tx_load), .TX_LAST(tx_last), .DMA_TX_WR(dma_wr), .DMA_TX_DATA(dma_data),
    .DMA_RX_RD(dma_rd), .RX_DATA(rx_data), .TX_DATA(tx_data), .RX_HALT(rx_halt), .TX_BLOCK(tx_block), .IRQ(irq));
  serial_peer peer_u (.clk(ref_clk), .rx_end(rx_end), .rx_char(rx_char), .par_bit(rx_par), .stop_bit(rx_stop),
    .mp_bit(rx_mp), .tx_load(tx_load), .tx_last(tx_last));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic conclude;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  // request held until pready is sampled high; a bound of 50 cycles ends a wait that never sees it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) miscompares++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  ////////////////////////////////////////////////////////////////
  // reference model of the status register, reading arms the bits seen as one
  task automatic rd_st;
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(r, 32'(st));
    arm = st;
  endtask : rd_st
  task automatic wr_st(input logic [7:0] v);
    int clr;
    apb(1'b1, `OFS_STATUS, {24'h0, v});
    clr = arm & ~v & 'hF8;
    st = st & ~clr;
    if (clr[`B_TXE]) st[`B_TX_END_FLAG] = 0;
    arm = 0;
  endtask : wr_st
  task automatic wrc(input logic [7:0] v);
    apb(1'b1, `OFS_CTRL, {24'h0, v});
    if (ctl[`C_TXON] && !v[`C_TXON]) st = st | 'h84;
    ctl = v;
  endtask : wrc
  task automatic rx(input logic [7:0] ch, input logic p, input logic s, input logic m);
    peer_u.send(ch, p, s, m, $urandom % 3);
    if (ctl[`C_RXON] && (st & 'h38) == 0) begin
      if (st[`B_RXF]) st[`B_OVR] = 1;
      else begin
        rxd = ch;
        if (ctl[`C_MPF] && !ctl[`C_SYNC]) st[`B_MPB] = m;
        if (!ctl[`C_SYNC] && !s) st[`B_FRM] = 1;
        if (!ctl[`C_SYNC] && ctl[`C_PEN] && ((^ch ^ p) != ctl[`C_ODD])) st[`B_PAR] = 1;
        if ((st & 'h18) == 0) st[`B_RXF] = 1;
      end
    end
    repeat (3) @(posedge ref_clk);
    chk(32'(rx_data), 32'(rxd));
    chk(32'(rx_halt), 32'((st & 'h38) != 0));
    chk(32'(tx_block), 32'(ctl[`C_SYNC] && (st & 'h38) != 0));
  endtask : rx
  task automatic dma(input logic wr, input logic [7:0] d);
    @(posedge ref_clk);
    if (wr) dma_wr <= 1'b1;
    else dma_rd <= 1'b1;
    dma_data <= d;
    @(posedge ref_clk);
    dma_wr <= 1'b0;
    dma_rd <= 1'b0;
    dma_data <= ~d;
    @(posedge ref_clk);
    if (wr) st = st & ~'h84;
    else st[`B_RXF] = 0;
    if (wr) txd = d;
    chk(32'(tx_data), 32'(txd));
  endtask : dma
  ////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    miscompares++;
    conclude();
  end
  initial begin
    void'($urandom(70));
    st = `STATUS_RST;
    {ctl, arm, rxd, txd} = '0;
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd_st();
    wr_st(8'hFF);
    rd_st();
    wr_st(8'h00);
    rd_st();
    peer_u.tx_pulse(1'b1);
    st[`B_TXE] = 1;
    peer_u.tx_pulse(1'b0);
    st[`B_TX_END_FLAG] = 1;
    rd_st();
    dma(1'b1, 8'($urandom));
    peer_u.tx_pulse(1'b0);
    rd_st();
    wrc(8'h02);
    peer_u.tx_pulse(1'b1);
    st[`B_TXE] = 1;
    wrc(8'h01);
    rd_st();
    // receive: good, overrun, ignored while halted, unarmed clear, receiver off
    rx(8'($urandom), 1'b0, 1'b1, 1'b0);
    rd_st();
    rx(8'($urandom), 1'b0, 1'b1, 1'b0);
    rx(8'($urandom), 1'b0, 1'b0, 1'b0);
    wr_st(8'h00);
    rd_st();
    wrc(8'h00);
    rd_st();
    wr_st(8'h00);
    rd_st();
    // synchronous mode: no framing check, overrun blocks transmit, interrupt
    apb(1'b1, `OFS_IRQ_ST, 32'h1F);
    apb(1'b1, `OFS_IRQ_MASK, 32'h01);
    wrc(8'h05);
    rx(8'($urandom), 1'b0, 1'b0, 1'b0);
    rx(8'($urandom), 1'b0, 1'b1, 1'b0);
    chk(32'(irq), 32'h1);
    apb(1'b0, `OFS_IRQ_ST, 32'h0);
    chk(r & 32'h1, 32'h1);
    apb(1'b1, `OFS_IRQ_ST, 32'h1F);
    repeat (3) @(posedge ref_clk);
    chk(32'(irq), 32'h0);
    rd_st();
    wr_st(8'h00);
    // asynchronous framing, parity and multiprocessor cases across modes
    for (int i = 0; i < 24; i++) begin
      wrc(8'h09 | (i[0] ? 8'h10 : 8'h00) | (i[1] ? 8'h20 : 8'h00) | (i[2] ? 8'h40 : 8'h00));
      rx(8'($urandom), 1'($urandom), ($urandom % 4) != 0, 1'($urandom));
      rd_st();
      if (st[`B_RXF] && i[3]) dma(1'b0, 8'h00);
      else wr_st(8'h00);
      rd_st();
    end
    apb(1'b0, 12'h0FC, 32'h0);
    chk({r[30:0], e}, 32'h1);
    standby <= 1'b1;
    repeat (4) @(posedge ref_clk);
    standby <= 1'b0;
    repeat (4) @(posedge ref_clk);
    st = `STATUS_RST;
    rd_st();
    conclude();
  end
endmodule : tb
